// File: design/dcs_dma.sv
`timescale 1ns/1ns
module dcs_dma
  import dcs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              ready_pin,
  input  wire logic              bus_ack_pin,
  input  wire logic [7:0]        data_in,
  output logic                   bus_req,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [7:0]             data_out,
  output logic                   data_oe,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic                   memory_request_strobe_n,
  output logic                   io_request_strobe_n,
  output logic                   irq
);

  if (ADDR_W < 8 || ADDR_W > 16) begin : g_chk
    $error("dcs_dma: ADDR_W must be 8 to 16");
  end

  // three-stage sync for pins; a change counts once stages two and three agree
  logic [1:0] sync1, sync2, sync3, pin_flt;
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1[i]   <= 1'b0;
        sync2[i]   <= 1'b0;
        sync3[i]   <= 1'b0;
        pin_flt[i] <= 1'b0;
      end else begin
        sync1[i] <= (i == 0) ? ready_pin : bus_ack_pin;
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          pin_flt[i] <= sync3[i];
        end
      end
    end
  end

  // software-visible state
  logic [ADDR_W-1:0]    a_start, b_start, a_cnt, b_cnt;
  logic [15:0]          block_len, byte_cnt;
  logic [CFG_W-1:0]     cfg;
  logic [TIM_REG_W-1:0] tim;
  logic [15:0]          mat;
  logic                 enabled, forced, rdy_latch, rdy_served;
  logic                 int_en, ip, match_n, eob_n, req_seen, stop_req;
  // engine state
  dcs_state_t           state;
  logic [TIM_W-1:0]     tcnt;
  // next values
  logic [ADDR_W-1:0]    next_a_start, next_b_start, next_a_cnt, next_b_cnt;
  logic [15:0]          next_block_len, next_byte_cnt, next_mat;
  logic [CFG_W-1:0]     next_cfg;
  logic [TIM_REG_W-1:0] next_tim;
  logic                 next_enabled, next_forced, next_rdy_latch, next_rdy_served;
  logic                 next_int_en, next_ip, next_match_n, next_eob_n;
  logic                 next_req_seen, next_stop_req;
  dcs_state_t           next_state;
  logic [TIM_W-1:0]     next_tcnt;
  logic                 next_pready, next_pslverr, next_bus_req, next_rd_n, next_wr_n;
  logic                 next_memory_request_strobe_n, next_io_request_strobe_n, next_irq, next_data_oe;
  logic [31:0]          next_prdata;
  logic [ADDR_W-1:0]    next_addr_out;
  logic [7:0]           next_data_out;

  // decoded helpers
  logic       wr_acc, setup, rdy_act, rdy_eff, src_a, src_fixed, dst_fixed;
  logic       src_io, dst_io, last_byte, is_cmd;
  logic [7:0] cmd;
  logic [TIM_W-1:0] src_w, dst_w;

  always_comb begin
    setup     = psel && !penable;
    wr_acc    = psel && penable && pready && pwrite;
    is_cmd    = wr_acc && (paddr == OFF_CMD);
    cmd       = pwdata[7:0];
    rdy_act   = (pin_flt[0] == cfg[CFG_RDY_HIGH]);
    rdy_eff   = rdy_act || forced;
    src_a     = cfg[CFG_A_SRC];
    src_fixed = src_a ? cfg[CFG_A_FIXED] : cfg[CFG_B_FIXED];
    dst_fixed = src_a ? cfg[CFG_B_FIXED] : cfg[CFG_A_FIXED];
    // per-port strobe width and port kind
    src_w     = src_a ? tim[TIM_A_LSB +: TIM_W] : tim[TIM_B_LSB +: TIM_W];
    dst_w     = src_a ? tim[TIM_B_LSB +: TIM_W] : tim[TIM_A_LSB +: TIM_W];
    src_io    = src_a ? tim[TIM_A_IO] : tim[TIM_B_IO];
    dst_io    = src_a ? tim[TIM_B_IO] : tim[TIM_A_IO];
    // a block moves one byte more than its programmed length
    last_byte = (byte_cnt == 16'(block_len + 16'h0001));
  end

  // register file, commands and transfer engine
  always_comb begin
    next_a_start    = a_start;
    next_b_start    = b_start;
    next_a_cnt      = a_cnt;
    next_b_cnt      = b_cnt;
    next_block_len  = block_len;
    next_byte_cnt   = byte_cnt;
    next_cfg        = cfg;
    next_tim        = tim;
    next_mat        = mat;
    next_enabled    = enabled;
    next_forced     = forced;
    next_rdy_latch  = rdy_latch;
    next_rdy_served = rdy_served;
    next_int_en     = int_en;
    next_ip         = ip;
    next_match_n    = match_n;
    next_eob_n      = eob_n;
    next_req_seen   = req_seen;
    next_stop_req   = stop_req;
    next_state      = state;
    next_tcnt       = tcnt;
    next_bus_req    = bus_req;
    next_rd_n       = 1'b1;
    next_wr_n       = 1'b1;
    next_memory_request_strobe_n     = 1'b1;
    next_io_request_strobe_n     = 1'b1;
    next_addr_out   = addr_out;
    next_data_out   = data_out;
    next_data_oe    = 1'b0;
    next_irq        = int_en && ip;
    // zero-wait slave: answer in the first access cycle
    next_pready     = setup;
    next_pslverr    = 1'b0;
    next_prdata     = 32'h0000_0000;

    // read decode, registered one cycle ahead of the access phase
    if (setup) begin
      unique case (paddr)
        OFF_A_START: next_prdata = 32'(a_start);
        OFF_B_START: next_prdata = 32'(b_start);
        OFF_LEN:     next_prdata = 32'(block_len);
        OFF_CFG:     next_prdata = 32'(cfg);
        OFF_TIM:     next_prdata = 32'(tim);
        OFF_MATCH:   next_prdata = 32'(mat);
        OFF_CMD:     next_prdata = 32'h0000_0000;
        OFF_STAT: begin
          next_prdata[ST_REQ]     = req_seen;
          next_prdata[ST_RDY]     = rdy_act;
          next_prdata[ST_IP_N]    = !ip;
          next_prdata[ST_MATCH_N] = match_n;
          next_prdata[ST_EOB_N]   = eob_n;
          next_prdata[ST_ENA]     = enabled;
        end
        OFF_A_CNT:   next_prdata = 32'(a_cnt);
        OFF_B_CNT:   next_prdata = 32'(b_cnt);
        OFF_BYTES:   next_prdata = 32'(byte_cnt);
        default:     next_pslverr = 1'b1;
      endcase
    end

    // control writes; start addresses land only in the start registers
    if (wr_acc) begin
      unique case (paddr)
        OFF_A_START: next_a_start = pwdata[ADDR_W-1:0];
        OFF_B_START: next_b_start = pwdata[ADDR_W-1:0];
        OFF_LEN:     next_block_len = pwdata[15:0];
        OFF_TIM:     next_tim = pwdata[TIM_REG_W-1:0];
        OFF_MATCH:   next_mat = pwdata[15:0];
        OFF_CFG: begin
          // direction byte may keep running; bit doubles as start
          next_cfg     = pwdata[CFG_W-1:0];
          next_enabled = pwdata[CFG_ENABLE];
        end
        default: ;
      endcase
      // writes other than config, status and the enable or rearm commands stop the engine
      if (paddr != OFF_CFG && paddr != OFF_STAT &&
          !(is_cmd && (cmd == CMD_ENABLE || cmd == CMD_REARM))) begin
        next_enabled = 1'b0;
      end
    end

    if (is_cmd) begin
      unique case (cmd)
        CMD_LOAD: begin
          // only the source counter takes a fixed address
          if (src_a || !cfg[CFG_A_FIXED]) next_a_cnt = a_start;
          if (!src_a || !cfg[CFG_B_FIXED]) next_b_cnt = b_start;
          next_byte_cnt   = 16'h0000;
          next_eob_n      = 1'b1;
          next_req_seen   = 1'b0;
          next_rdy_served = 1'b0;
          next_forced     = 1'b0;
        end
        CMD_CONT: begin
          next_byte_cnt   = 16'h0000;
          next_eob_n      = 1'b1;
          next_rdy_served = 1'b0;
          next_forced     = 1'b0;
        end
        CMD_ENABLE:  next_enabled = 1'b1;
        CMD_DISABLE: next_forced = 1'b0;
        CMD_FORCE:   next_forced = 1'b1;
        CMD_REARM: begin
          next_match_n = 1'b1;
          next_eob_n   = 1'b1;
        end
        CMD_RL_CLR:  next_rdy_latch = 1'b0;
        CMD_INT_EN:  next_int_en = 1'b1;
        CMD_INT_DIS: next_int_en = 1'b0;
        CMD_INT_RST: begin
          next_int_en = 1'b0;
          next_ip     = 1'b0;
        end
        default: ;
      endcase
    end

    // transfer engine; hardware-set flags come after clears so a set wins
    unique case (state)
      S_IDLE: begin
        if (enabled && rdy_eff && !rdy_latch) begin
          if (cfg[CFG_INT_RDY] && !rdy_served) begin
            // interrupt while the host still owns the bus
            next_ip         = 1'b1;
            next_rdy_latch  = 1'b1;
            next_rdy_served = 1'b1;
          end else if (!pin_flt[1]) begin
            // wait for the last grant to drop, else a stale acknowledge is taken
            next_bus_req  = 1'b1;
            next_req_seen = 1'b1;
            next_state    = S_REQ;
          end
        end
      end
      S_REQ: begin
        if (pin_flt[1]) begin
          next_state    = S_RD;
          next_tcnt     = src_w;
          next_addr_out = src_a ? a_cnt : b_cnt;
          next_rd_n     = 1'b0;
          next_memory_request_strobe_n   = src_io;
          next_io_request_strobe_n   = !src_io;
        end
      end
      S_RD: begin
        if (tcnt != '0) begin
          // hold read strobes for one cycle more than the programmed width
          next_tcnt   = TIM_W'(tcnt - 1'b1);
          next_rd_n   = 1'b0;
          next_memory_request_strobe_n = src_io;
          next_io_request_strobe_n = !src_io;
        end else begin
          next_data_out = data_in;
          next_byte_cnt = 16'(byte_cnt + 16'h0001);
          if (!src_fixed) begin
            if (src_a) next_a_cnt = ADDR_W'(a_cnt + 1'b1);
            else next_b_cnt = ADDR_W'(b_cnt + 1'b1);
          end
          if (cfg[CFG_STOP_MAT] && data_in == mat[MAT_BYTE_LSB +: 8]) begin
            next_match_n  = 1'b0;
            next_stop_req = 1'b1;
          end
          next_state    = S_WR;
          next_tcnt     = dst_w;
          next_addr_out = src_a ? b_cnt : a_cnt;
          next_wr_n     = 1'b0;
          next_data_oe  = 1'b1;
          next_memory_request_strobe_n   = dst_io;
          next_io_request_strobe_n   = !dst_io;
        end
      end
      S_WR: begin
        if (tcnt != '0) begin
          next_tcnt    = TIM_W'(tcnt - 1'b1);
          next_wr_n    = 1'b0;
          next_data_oe = 1'b1;
          next_memory_request_strobe_n  = dst_io;
          next_io_request_strobe_n  = !dst_io;
        end else begin
          if (!dst_fixed) begin
            if (src_a) next_b_cnt = ADDR_W'(b_cnt + 1'b1);
            else next_a_cnt = ADDR_W'(a_cnt + 1'b1);
          end
          // pulse on the interrupt pin when the low count hits the offset
          if (cfg[CFG_PULSE] && byte_cnt[7:0] == mat[MAT_PULSE_LSB +: 8]) begin
            next_irq = 1'b1;
          end
          if (last_byte) begin
            next_eob_n = 1'b0;
            if (cfg[CFG_AUTO] && !stop_req) begin
              // fresh start addresses are taken here and on a load command
              next_a_cnt    = a_start;
              next_b_cnt    = b_start;
              next_byte_cnt = 16'h0000;
            end else begin
              next_stop_req = 1'b1;
            end
          end
          if (stop_req || (last_byte && !cfg[CFG_AUTO]) || !enabled || !rdy_eff) begin
            next_state   = S_REL;
            next_bus_req = 1'b0;
          end else begin
            next_state    = S_RD;
            next_tcnt     = src_w;
            next_addr_out = src_a ? next_a_cnt : next_b_cnt;
            next_rd_n     = 1'b0;
            next_memory_request_strobe_n   = src_io;
            next_io_request_strobe_n   = !src_io;
          end
        end
      end
      S_REL: begin
        // block and match events are raised only once the bus is back
        if (stop_req) begin
          next_enabled  = 1'b0;
          next_stop_req = 1'b0;
          if ((!eob_n && cfg[CFG_INT_EOB]) || (!match_n && cfg[CFG_INT_MAT])) begin
            next_ip = 1'b1;
          end
        end
        next_state = S_IDLE;
      end
    endcase
  end

  // one register stage for everything above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_start                 <= '0;
      b_start                 <= '0;
      a_cnt                   <= '0;
      b_cnt                   <= '0;
      block_len               <= 16'h0000;
      byte_cnt                <= 16'h0000;
      cfg                     <= '0;
      tim                     <= '0;
      mat                     <= 16'h0000;
      enabled                 <= 1'b0;
      forced                  <= 1'b0;
      rdy_latch               <= 1'b0;
      rdy_served              <= 1'b0;
      int_en                  <= 1'b0;
      ip                      <= 1'b0;
      match_n                 <= 1'b1;
      eob_n                   <= 1'b1;
      req_seen                <= 1'b0;
      stop_req                <= 1'b0;
      state                   <= S_IDLE;
      tcnt                    <= '0;
      pready                  <= 1'b0;
      prdata                  <= 32'h0000_0000;
      pslverr                 <= 1'b0;
      bus_req                 <= 1'b0;
      addr_out                <= '0;
      data_out                <= 8'h00;
      data_oe                 <= 1'b0;
      rd_n                    <= 1'b1;
      wr_n                    <= 1'b1;
      memory_request_strobe_n <= 1'b1;
      io_request_strobe_n     <= 1'b1;
      irq                     <= 1'b0;
    end else begin
      a_start                 <= next_a_start;
      b_start                 <= next_b_start;
      a_cnt                   <= next_a_cnt;
      b_cnt                   <= next_b_cnt;
      block_len               <= next_block_len;
      byte_cnt                <= next_byte_cnt;
      cfg                     <= next_cfg;
      tim                     <= next_tim;
      mat                     <= next_mat;
      enabled                 <= next_enabled;
      forced                  <= next_forced;
      rdy_latch               <= next_rdy_latch;
      rdy_served              <= next_rdy_served;
      int_en                  <= next_int_en;
      ip                      <= next_ip;
      match_n                 <= next_match_n;
      eob_n                   <= next_eob_n;
      req_seen                <= next_req_seen;
      stop_req                <= next_stop_req;
      state                   <= next_state;
      tcnt                    <= next_tcnt;
      pready                  <= next_pready;
      prdata                  <= next_prdata;
      pslverr                 <= next_pslverr;
      bus_req                 <= next_bus_req;
      addr_out                <= next_addr_out;
      data_out                <= next_data_out;
      data_oe                 <= next_data_oe;
      rd_n                    <= next_rd_n;
      wr_n                    <= next_wr_n;
      memory_request_strobe_n <= next_memory_request_strobe_n;
      io_request_strobe_n     <= next_io_request_strobe_n;
      irq                     <= next_irq;
    end
  end

endmodule

// File: design/dcs_pkg.sv
package dcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_A_START = 8'h00;
  localparam logic [7:0] OFF_B_START = 8'h04;
  localparam logic [7:0] OFF_LEN     = 8'h08;
  localparam logic [7:0] OFF_CFG     = 8'h0c;
  localparam logic [7:0] OFF_TIM     = 8'h10;
  localparam logic [7:0] OFF_MATCH   = 8'h14;
  localparam logic [7:0] OFF_CMD     = 8'h18;
  localparam logic [7:0] OFF_STAT    = 8'h1c;
  localparam logic [7:0] OFF_A_CNT   = 8'h20;
  localparam logic [7:0] OFF_B_CNT   = 8'h24;
  localparam logic [7:0] OFF_BYTES   = 8'h28;
  // configuration bits
  localparam int CFG_A_FIXED  = 0;
  localparam int CFG_B_FIXED  = 1;
  localparam int CFG_A_SRC    = 2;
  localparam int CFG_RDY_HIGH = 3;
  localparam int CFG_INT_RDY  = 4;
  localparam int CFG_AUTO     = 5;
  localparam int CFG_ENABLE   = 6;
  localparam int CFG_INT_EOB  = 7;
  localparam int CFG_INT_MAT  = 8;
  localparam int CFG_STOP_MAT = 9;
  localparam int CFG_PULSE    = 10;
  localparam int CFG_W        = 11;
  // timing fields: strobe width per port and port kind
  localparam int TIM_W     = 4;
  localparam int TIM_A_LSB = 0;
  localparam int TIM_B_LSB = 4;
  localparam int TIM_A_IO  = 8;
  localparam int TIM_B_IO  = 9;
  localparam int TIM_REG_W = 10;
  // match register fields
  localparam int MAT_BYTE_LSB  = 0;
  localparam int MAT_PULSE_LSB = 8;
  // status bits
  localparam int ST_REQ     = 0;
  localparam int ST_RDY     = 1;
  localparam int ST_IP_N    = 3;
  localparam int ST_MATCH_N = 4;
  localparam int ST_EOB_N   = 5;
  localparam int ST_ENA     = 6;
  // command codes
  localparam logic [7:0] CMD_LOAD    = 8'h01;
  localparam logic [7:0] CMD_CONT    = 8'h02;
  localparam logic [7:0] CMD_ENABLE  = 8'h03;
  localparam logic [7:0] CMD_DISABLE = 8'h04;
  localparam logic [7:0] CMD_FORCE   = 8'h05;
  localparam logic [7:0] CMD_REARM   = 8'h06;
  localparam logic [7:0] CMD_RL_CLR  = 8'h07;
  localparam logic [7:0] CMD_INT_EN  = 8'h08;
  localparam logic [7:0] CMD_INT_DIS = 8'h09;
  localparam logic [7:0] CMD_INT_RST = 8'h0a;
  // engine states
  typedef enum logic [2:0] {
    S_IDLE,
    S_REQ,
    S_RD,
    S_WR,
    S_REL
  } dcs_state_t;
endpackage

// File: sim/dcs_far_model.sv
`timescale 1ns/1ns
module dcs_far_model (
  input  wire logic        pclk,
  input  wire logic        bus_req,
  input  wire logic        rd_n,
  input  wire logic [15:0] addr_out,
  input  wire logic        slow,
  output logic             bus_ack_pin,
  output logic [7:0]       data_in
);
  logic [3:0] wait_cnt = 4'h0;
  logic       ack_q    = 1'b0;
  logic [7:0] last     = 8'h5a;
  // grant after a short or long wait, dropped with the request
  always @(posedge pclk) begin
    // saturate so a long hold never drops the grant mid-ownership
    wait_cnt <= !bus_req ? 4'h0 : (wait_cnt == 4'hf) ? wait_cnt : wait_cnt + 4'h1;
    ack_q    <= bus_req && (wait_cnt >= (slow ? 4'h6 : 4'h1));
  end
  // memory echoes the low address byte; a released bus toggles so stale data shows
  assign data_in     = rd_n ? ~last : addr_out[7:0];
  assign bus_ack_pin = ack_q;
  always @(posedge pclk) last <= data_in;
endmodule

// File: sim/dcs_checker.sv
`timescale 1ns/1ns
module dcs_checker
  import dcs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        bus_req,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        memory_request_strobe_n,
  input wire logic        io_request_strobe_n,
  input wire logic        irq
);
  logic             wr_tk, cmd_wr, start_wr, kill_wr, stop_frc;
  logic             en_seen, forced, lat, irq_q, next_en, next_frc, next_lat;
  logic [CFG_W-1:0] cfg, next_cfg;
  // decode of writes taken on the bus
  assign wr_tk    = psel && penable && pready && pwrite;
  assign cmd_wr   = wr_tk && paddr == OFF_CMD;
  assign start_wr = cmd_wr && pwdata[7:0] == CMD_ENABLE
                    || wr_tk && paddr == OFF_CFG && pwdata[CFG_ENABLE];
  assign kill_wr  = wr_tk && !start_wr && paddr <= OFF_BYTES && paddr != OFF_STAT
                    && !(cmd_wr && pwdata[7:0] == CMD_REARM);
  assign stop_frc = cmd_wr && pwdata[7:0] inside {CMD_LOAD, CMD_CONT, CMD_DISABLE};
  // bus-side shadow of enable, force, config and ready latch
  always_comb begin
    next_en  = start_wr || en_seen && !kill_wr;
    next_frc = !stop_frc && (forced || cmd_wr && pwdata[7:0] == CMD_FORCE);
    next_cfg = (wr_tk && paddr == OFF_CFG) ? pwdata[CFG_W-1:0] : cfg;
    next_lat = !(cmd_wr && pwdata[7:0] == CMD_RL_CLR)
               && (lat || irq && !irq_q && !bus_req && cfg[CFG_INT_RDY] && !cfg[CFG_PULSE]);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen <= 1'b0;
      forced  <= 1'b0;
      cfg     <= '0;
      lat     <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      en_seen <= next_en;
      forced  <= next_frc;
      cfg     <= next_cfg;
      lat     <= next_lat;
      irq_q   <= irq;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_forced_start;
    start_wr && forced && !cfg[CFG_INT_RDY];
  endsequence
  sequence s_quick_req;
    ##[1:6] bus_req;
  endsequence
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  run_needs_start_a: assert property ($rose(bus_req) |-> en_seen)
    else $error("bus requested without start");
  write_disables_a: assert property (kill_wr |=> (!$rose(bus_req))[*2])
    else $error("request after disabling write");
  ready_latch_a: assert property (lat |-> !$rose(bus_req))
    else $error("request while ready latch set");
  irq_release_a: assert property ($rose(irq) && !cfg[CFG_PULSE] |-> !bus_req)
    else $error("interrupt while owning bus");
  strobe_owned_a: assert property (!rd_n || !wr_n |-> bus_req)
    else $error("strobe without bus request");
  strobe_kind_a: assert property ($fell(rd_n) |-> memory_request_strobe_n != io_request_strobe_n)
    else $error("strobe kind wrong");
  pulse_width_a: assert property (cfg[CFG_PULSE] && $rose(irq) |=> !irq)
    else $error("pulse longer than one cycle");
  start_at_once_a: assert property (s_forced_start |-> s_quick_req)
    else $error("no request after forced start");
endmodule
bind dcs_dma dcs_checker dcs_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .bus_req, .rd_n, .wr_n, .memory_request_strobe_n, .io_request_strobe_n,
  .irq);

// File: sim/tb_dma_command_sequencing.sv
`timescale 1ns/1ns
module tb_dma_command_sequencing;
  import dcs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ready_pin, bus_ack_pin;
  logic        bus_req, data_oe, rd_n, wr_n, irq, slow, rd_err;
  logic        memory_request_strobe_n, io_request_strobe_n;
  logic [7:0]  paddr, data_in, data_out;
  logic [15:0] addr_out;
  logic [31:0] pwdata, prdata, rd_val;
  int          bad_count, tests_run, n;
  dcs_dma #(.ADDR_W(16)) dcs_dma_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .ready_pin, .bus_ack_pin, .data_in, .bus_req,
    .addr_out, .data_out, .data_oe, .rd_n, .wr_n, .memory_request_strobe_n,
    .io_request_strobe_n, .irq);
  dcs_far_model dcs_far_model_inst (.pclk, .bus_req, .rd_n, .addr_out, .slow, .bus_ack_pin,
    .data_in);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one transfer; pready and read data are taken at the rising edge that samples them,
  // no wait count assumed, only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, OFF_CMD, {24'h0, c});
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic irq_cmd(input logic [7:0] c, input logic e);
    cmd(c);
    repeat (2) @(negedge pclk);
    check(32'(irq), 32'(e), "irq level");
  endtask
  task automatic t_load;
    check(32'({bus_req, rd_n, wr_n, irq}), 32'h6, "reset pins");
    apb(1'b0, 8'h40, 32'h0);
    check(32'({rd_err, rd_val[30:0]}), 32'h8000_0000, "unmapped read");
    apb(1'b1, OFF_B_START, 32'h55);
    apb(1'b1, OFF_CFG, 32'h2);           // port B fixed, B source for now
    cmd(CMD_LOAD);
    apb(1'b1, OFF_A_START, 32'h1234);
    apb(1'b1, OFF_B_START, 32'h66);
    apb(1'b1, OFF_CFG, 32'h6);           // port A becomes source
    cmd(CMD_LOAD);
    apb(1'b1, OFF_A_START, 32'h2345);
    apb(1'b0, OFF_A_CNT, 32'h0);
    check(rd_val, 32'h1234, "A counter");
    apb(1'b0, OFF_B_CNT, 32'h0);
    check(rd_val, 32'h55, "B counter");
    $display("test load done");
  endtask
  task automatic t_xfer;
    apb(1'b1, OFF_TIM, 32'h201);         // A memory 2 cycles, B io 1 cycle
    apb(1'b1, OFF_LEN, 32'h2);
    cmd(CMD_LOAD);
    cmd(CMD_FORCE);
    cmd(CMD_ENABLE);
    wait_for(bus_req, 1'b1, 4);
    check(32'(bus_req), 32'h1, "request on start");
    wait_for(rd_n, 1'b0, 20);
    check(32'({memory_request_strobe_n, io_request_strobe_n, addr_out}), 32'h12345, "rd A");
    wait_for(rd_n, 1'b1, 20);
    check(32'(n), 32'h2, "A width");
    wait_for(wr_n, 1'b0, 8);
    check(32'({data_oe, memory_request_strobe_n, io_request_strobe_n, data_out}), 32'h645,
          "wr B");
    wait_for(wr_n, 1'b1, 8);
    check(32'(n), 32'h1, "B width");
    wait_for(bus_req, 1'b0, 100);
    apb(1'b0, OFF_BYTES, 32'h0);
    check(rd_val, 32'h3, "byte count");
    apb(1'b0, OFF_STAT, 32'h0);
    check(32'(rd_val[ST_EOB_N]), 32'h0, "eob flag");
    cmd(CMD_LOAD);
    cmd(CMD_REARM);
    apb(1'b0, OFF_STAT, 32'h0);
    check(32'(rd_val[ST_EOB_N:ST_MATCH_N]), 32'h3, "rearm");
    $display("test transfer done");
  endtask
  task automatic t_rdyint;
    apb(1'b1, OFF_CFG, 32'h1e);          // ready active high, irq on ready
    cmd(CMD_INT_EN);
    cmd(CMD_LOAD);
    ready_pin <= 1'b1;
    cmd(CMD_ENABLE);
    wait_for(irq, 1'b1, 12);
    check(32'({irq, bus_req}), 32'h2, "ready irq first");
    cmd(CMD_ENABLE);
    repeat (8) @(negedge pclk);
    check(32'(bus_req), 32'h0, "latched off");
    cmd(CMD_RL_CLR);
    cmd(CMD_ENABLE);
    wait_for(bus_req, 1'b1, 12);
    check(32'(bus_req), 32'h1, "request after clear");
    wait_for(bus_req, 1'b0, 100);
    @(posedge pclk);
    ready_pin <= 1'b0;
    apb(1'b1, OFF_CFG, 32'h6);
    irq_cmd(CMD_INT_DIS, 1'b0);
    irq_cmd(CMD_INT_RST, 1'b0);
    irq_cmd(CMD_INT_EN, 1'b0);
    $display("test ready irq done");
  endtask
  task automatic t_auto;
    apb(1'b1, OFF_MATCH, 32'h100);       // pulse offset 1
    apb(1'b1, OFF_LEN, 32'h0);
    apb(1'b1, OFF_A_START, 32'h100);
    apb(1'b1, OFF_CFG, 32'h427);         // fixed ports, auto restart, pulses
    slow <= 1'b1;
    cmd(CMD_INT_EN);
    cmd(CMD_LOAD);
    cmd(CMD_FORCE);
    cmd(CMD_ENABLE);
    wait_for(irq, 1'b1, 60);
    check(32'(irq), 32'h1, "pulse seen");
    @(negedge pclk);
    check(32'(irq), 32'h0, "pulse ends");
    apb(1'b1, OFF_A_START, 32'h200);
    cmd(CMD_ENABLE);
    wait_for(rd_n, 1'b0, 60);
    wait_for(rd_n, 1'b1, 20);
    wait_for(rd_n, 1'b0, 60);
    check(32'(addr_out), 32'h200, "restart address");
    cmd(CMD_DISABLE);
    wait_for(bus_req, 1'b0, 60);
    check(32'(bus_req), 32'h0, "stopped");
    $display("test auto restart done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, ready_pin, slow, presetn} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_load();
    t_xfer();
    t_rdyint();
    t_auto();
    report_and_stop();
  end
endmodule
